// [src/cpex_top.sv]
// channel slave: parity checking, address-parity decode, channel check
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - streaming write channel check gated by parity enable
// - check parity only on lanes marked valid
// - data source supplies parity on every valid lane
// - write parity error: channel check, clear status bit
// - address parity valid with address, used bytes
// - address parity error blocks selection and feedback
// - address parity error: channel check, status unchanged
// - address commands run only with good parity
// - preemption timeout forces owner off the buses
// - slave reports exceptions by channel check pulse
// - parity disabled after reset, no checks then
// - writing one to status bit restores idle
module cpex_top
	import cpex_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic [2:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [7:0]  o_reg_rdata,
	input  wire logic        i_adl_n,
	input  wire logic [31:0] i_addr,
	input  wire logic [3:0]  i_addr_par,
	input  wire logic        i_addr_parity_enable_n,
	input  wire logic        i_mem_io,
	input  wire logic        i_write,
	input  wire logic        i_streaming,
	input  wire logic        i_cmd_n,
	input  wire logic        i_sd_strobe_n,
	input  wire logic [31:0] i_data,
	input  wire logic [3:0]  i_data_par,
	input  wire logic        i_data_parity_enable_n,
	input  wire logic        i_be_mode,
	input  wire logic        i_high_byte_enable_n,
	input  wire logic [3:0]  i_byte_enables_n,
	input  wire logic        i_arb_grant_state,
	input  wire logic        i_request_n_a,
	input  wire logic [31:0] i_user_rd_data,
	output logic             o_card_selected_feedback_n,
	output logic             o_channel_check_n,
	output logic             o_channel_check_oe,
	output logic             o_data_parity_enable_n,
	output logic             o_data_parity_enable_oe,
	output logic      [31:0] o_rd_data,
	output logic      [3:0]  o_rd_data_par,
	output logic             o_rd_data_oe,
	output logic             o_selected,
	output logic             o_cmd_go,
	output logic             o_wr_valid,
	output logic      [31:0] o_wr_data,
	output logic             o_wr_par_err
);
	logic [7:0]  ctrl_q, ctrl_d, base_q, base_d, stat_q, stat_d;
	logic [7:0]  cause_q, cause_d, rdata_q, rdata_d;
	logic        sel_q, sel_d, wr_q, wr_d, strm_q, strm_d;
	logic        csp_q, csp_d, cdfb_n_q, cdfb_n_d, go_q, go_d, cmd_n_q;
	logic        act_q, act_d, ck_oe_q, ck_oe_d, ck_n_q, ck_n_d;
	logic [1:0]  cnt_q, cnt_d;
	cpex_dp_t    dp_q, dp_d;
	logic        dpn_q, dpn_d, dpoe_q, dpoe_d, rdoe_q, rdoe_d;
	logic [31:0] rdd_q, rdd_d, wrd_q, wrd_d;
	logic [3:0]  rdp_q, rdp_d;
	logic        wrv_q, wrv_d, wpe_q, wpe_d;
	logic        par_en, card_en, addr_phase, addr_hit, apar_chk;
	logic        addr_err_ev, data_chk_cyc, data_err_ev, degate;
	logic        cmd_start, cmd_end, strm_wr, ck_gate, ck_hold;
	cpex_par_if apar_if ();
	cpex_par_if dpar_if ();
	cpex_par_if rpar_if ();
	cpex_wd_if  wd_if ();
	cpex_parity_chk u_apar (.p_if(apar_if.chk));
	cpex_parity_chk u_dpar (.p_if(dpar_if.chk));
	cpex_parity_chk u_rpar (.p_if(rpar_if.chk));
	cpex_request_n_a_wd u_wd (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.wd_if     (wd_if.wd)
	);

	// checker feeds; only the 16 i/o address bits need good parity
	assign apar_if.data = i_addr;
	assign apar_if.par  = i_addr_par;
	assign apar_if.mask = IO_ADDR_MASK;
	assign dpar_if.data = i_data;
	assign dpar_if.par  = i_data_par;
	assign dpar_if.mask = cpex_byte_valid(i_be_mode, i_addr[0],
		i_high_byte_enable_n, i_byte_enables_n);
	assign rpar_if.data = i_user_rd_data;
	assign rpar_if.par  = 4'h0;
	assign rpar_if.mask = 4'h0;
	assign wd_if.req_active = !i_request_n_a && sel_q;

	// decode terms and exception events
	assign par_en      = ctrl_q[CTRL_PAR_EN_BIT];
	assign card_en     = ctrl_q[CTRL_CARD_EN_BIT];
	assign addr_phase  = !i_adl_n;
	assign addr_hit    = card_en && !i_mem_io && (i_addr[15:8] == base_q);
	assign apar_chk    = par_en && !i_addr_parity_enable_n;
	// every i/o address is checked, ours or not
	assign addr_err_ev = addr_phase && !i_mem_io && apar_chk
		&& apar_if.err;
	assign cmd_start   = cmd_n_q && !i_cmd_n;
	assign cmd_end     = !cmd_n_q && i_cmd_n;
	assign data_chk_cyc = sel_q && wr_q && !i_cmd_n
		&& (strm_q ? !i_sd_strobe_n : 1'b1);
	assign data_err_ev = data_chk_cyc && par_en && !i_data_parity_enable_n
		&& dpar_if.err;
	assign degate      = i_arb_grant_state && wd_if.expired;
	assign strm_wr     = wr_q && strm_q;

	// selection and user strobes
	always_comb begin
		sel_d  = sel_q;
		wr_d   = wr_q;
		strm_d = strm_q;
		csp_d  = csp_q;
		if (degate) begin
			sel_d = 1'b0;
		end else if (addr_phase) begin
			// parity folded into decode: no select, no feedback
			sel_d  = addr_hit && !(apar_chk && apar_if.err);
			wr_d   = i_write;
			strm_d = i_streaming;
			csp_d  = i_addr[CMD_SPACE_BIT];
		end else if (cmd_end) begin
			sel_d = 1'b0;
		end
		cdfb_n_d = !sel_d;
		// selection already implies good address parity
		go_d  = sel_q && cmd_start && csp_q && wr_q;
		wrv_d = data_chk_cyc;
		wrd_d = i_data;
		wpe_d = data_err_ev;
		rdoe_d = sel_q && !wr_q && !i_cmd_n && !degate;
		rdd_d  = i_user_rd_data;
		rdp_d  = rpar_if.gen_par;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{sel_q, wr_q, strm_q, csp_q} <= 4'h0;
			{cdfb_n_q, go_q, cmd_n_q} <= 3'h5;
			{wrv_q, wrd_q, wpe_q} <= 34'h0;
			{rdoe_q, rdd_q, rdp_q} <= 37'h0;
		end else begin
			{sel_q, wr_q, strm_q, csp_q} <= {sel_d, wr_d, strm_d, csp_d};
			{cdfb_n_q, go_q, cmd_n_q} <= {cdfb_n_d, go_d, i_cmd_n};
			{wrv_q, wrd_q, wpe_q} <= {wrv_d, wrd_d, wpe_d};
			{rdoe_q, rdd_q, rdp_q} <= {rdoe_d, rdd_d, rdp_d};
		end
	end

	// read parity enable: drive, then restore high before floating
	always_comb begin
		dp_d = dp_q;
		case (dp_q)
			DP_IDLE: begin
				if (sel_q && !wr_q && !i_cmd_n && par_en && !degate) begin
					dp_d = DP_DRIVE;
				end
			end
			DP_DRIVE: begin
				if (i_cmd_n || degate) begin
					dp_d = DP_RESTORE;
				end
			end
			default: begin
				dp_d = DP_IDLE;
			end
		endcase
		dpn_d  = (dp_d != DP_DRIVE);
		dpoe_d = (dp_d != DP_IDLE);
	end

	// channel check pulse; streaming writes hold it by parity enable
	always_comb begin
		ck_gate = strm_wr ? !i_data_parity_enable_n : 1'b1;
		ck_hold = strm_wr ? !i_data_parity_enable_n : !i_cmd_n;
		act_d = act_q;
		cnt_d = cnt_q;
		if (addr_err_ev || data_err_ev) begin
			act_d = 1'b1;
			cnt_d = CHANNEL_CHECK_N_HOLD_LAST;
		end else if (act_q) begin
			if (cnt_q != 2'b00) begin
				cnt_d = cnt_q - 2'b01;
			end else if (!ck_hold) begin
				act_d = 1'b0;
			end
		end
		ck_oe_d = act_d && ck_gate;
		ck_n_d  = !ck_oe_d;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dp_q <= DP_IDLE;
			{dpn_q, dpoe_q} <= 2'b10;
			{act_q, cnt_q, ck_oe_q, ck_n_q} <= 5'h01;
		end else begin
			dp_q <= dp_d;
			{dpn_q, dpoe_q} <= {dpn_d, dpoe_d};
			{act_q, cnt_q} <= {act_d, cnt_d};
			{ck_oe_q, ck_n_q} <= {ck_oe_d, ck_n_d};
		end
	end

	// configuration registers; hardware error wins over a same-cycle write
	always_comb begin
		ctrl_d  = ctrl_q;
		base_d  = base_q;
		stat_d  = stat_q;
		cause_d = cause_q;
		rdata_d = 8'h00;
		if (i_reg_wr) begin
			if (i_reg_addr == REG_CTRL) begin
				ctrl_d = i_reg_wdata;
			end else if (i_reg_addr == REG_BASE) begin
				base_d = i_reg_wdata;
			end else if (i_reg_addr == REG_STAT) begin
				// a zero write is ignored rather than left undefined
				if (i_reg_wdata[STAT_CHANNEL_CHECK_N_BIT]) begin
					stat_d  = STAT_RST;
					cause_d = CAUSE_RST;
				end
			end
		end
		if (data_err_ev) begin
			stat_d[STAT_CHANNEL_CHECK_N_BIT]   = 1'b0;
			stat_d[STAT_AVAIL_BIT]  = 1'b0;
			cause_d[CAUSE_DPAR_BIT] = 1'b1;
		end
		if (addr_err_ev) begin
			cause_d[CAUSE_APAR_BIT] = 1'b1;
		end
		if (degate && sel_q) begin
			cause_d[CAUSE_TMO_BIT] = 1'b1;
		end
		if (i_reg_rd) begin
			if (i_reg_addr == REG_ID_LO) begin
				rdata_d = CARD_ID[7:0];
			end else if (i_reg_addr == REG_ID_HI) begin
				rdata_d = CARD_ID[15:8];
			end else if (i_reg_addr == REG_CTRL) begin
				rdata_d = ctrl_q;
			end else if (i_reg_addr == REG_BASE) begin
				rdata_d = base_q;
			end else if (i_reg_addr == REG_STAT) begin
				rdata_d = stat_q & STAT_MASK;
			end else if (i_reg_addr == REG_CAUSE) begin
				rdata_d = cause_q;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{ctrl_q, base_q} <= {CTRL_RST, BASE_RST};
			{stat_q, cause_q, rdata_q} <= {STAT_RST, CAUSE_RST, 8'h00};
		end else begin
			{ctrl_q, base_q, stat_q} <= {ctrl_d, base_d, stat_d};
			{cause_q, rdata_q} <= {cause_d, rdata_d};
		end
	end

	// every output straight from a flip-flop
	assign o_reg_rdata               = rdata_q;
	assign o_card_selected_feedback_n = cdfb_n_q;
	assign o_channel_check_n         = ck_n_q;
	assign o_channel_check_oe        = ck_oe_q;
	assign o_data_parity_enable_n    = dpn_q;
	assign o_data_parity_enable_oe   = dpoe_q;
	assign o_rd_data                 = rdd_q;
	assign o_rd_data_par             = rdp_q;
	assign o_rd_data_oe              = rdoe_q;
	assign o_selected                = sel_q;
	assign o_cmd_go                  = go_q;
	assign o_wr_valid                = wrv_q;
	assign o_wr_data                 = wrd_q;
	assign o_wr_par_err              = wpe_q;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	sel_parity_a: assert property (addr_phase && apar_chk && apar_if.err
		|=> !sel_q && o_card_selected_feedback_n)
		else $error("selected despite address parity error");
	fb_sel_a: assert property (!o_card_selected_feedback_n |-> sel_q)
		else $error("feedback driven while not selected");
	channel_check_n_gate_a: assert property (o_channel_check_oe && strm_wr
		|-> $past(!i_data_parity_enable_n))
		else $error("streaming check driven without parity enable");
	dperr_stat_a: assert property (data_err_ev
		|=> !stat_q[STAT_CHANNEL_CHECK_N_BIT] && act_q)
		else $error("write parity error not flagged");
	aperr_channel_check_n_a: assert property (addr_err_ev && !data_err_ev
		&& !(i_reg_wr && i_reg_addr == REG_STAT)
		|=> act_q && stat_q[STAT_CHANNEL_CHECK_N_BIT] == $past(stat_q[STAT_CHANNEL_CHECK_N_BIT]))
		else $error("address parity error handling wrong");
	w1_restore_a: assert property (i_reg_wr && i_reg_addr == REG_STAT
		&& i_reg_wdata[STAT_CHANNEL_CHECK_N_BIT] && !data_err_ev
		|=> stat_q[STAT_CHANNEL_CHECK_N_BIT] && cause_q[CAUSE_DPAR_BIT] == 1'b0)
		else $error("status bit not restored by write of one");
	par_off_a: assert property (!par_en && dp_q == DP_IDLE
		|=> o_data_parity_enable_n)
		else $error("parity enable driven while disabled");
	degate_a: assert property (degate
		|=> !o_rd_data_oe && !o_selected ##1 !o_data_parity_enable_oe)
		else $error("buses not released after timeout");
	channel_check_n_width_a: assert property ($rose(act_q) |-> act_q[*2])
		else $error("channel check pulse too short");
	cmd_go_a: assert property (o_cmd_go |-> $past(sel_q) && $past(csp_q))
		else $error("command run without good selection");
	cov_dperr_c: cover property (data_err_ev ##[1:4] o_channel_check_oe);
	cov_aperr_c: cover property (addr_err_ev ##1 !o_selected);
	cov_rdpar_c: cover property (dp_q == DP_DRIVE ##[1:20] dp_q == DP_RESTORE);
	cov_tmo_c: cover property (degate && sel_q);
endmodule : cpex_top

// [src/cpex_pkg.sv]
// constants, types and helpers shared by the channel parity exception block
package cpex_pkg;

	// clock and timing
	localparam int unsigned CLK_PERIOD_NS   = 40;
	localparam int unsigned REQUEST_N_A_TMO_NS  = 7800;
	// longest time, so round down
	localparam int unsigned REQUEST_N_A_TMO_CYC = REQUEST_N_A_TMO_NS / CLK_PERIOD_NS;
	localparam logic [7:0]  REQUEST_N_A_CNT_LAST = 8'(REQUEST_N_A_TMO_CYC - 1);
	localparam int unsigned CHANNEL_CHECK_N_MIN_NS     = 50;
	// least time, so round up
	localparam int unsigned CHANNEL_CHECK_N_MIN_CYC    =
		(CHANNEL_CHECK_N_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0]  CHANNEL_CHECK_N_HOLD_LAST  = 2'(CHANNEL_CHECK_N_MIN_CYC - 1);

	// configuration register indices
	localparam logic [2:0] REG_ID_LO = 3'h0;
	localparam logic [2:0] REG_ID_HI = 3'h1;
	localparam logic [2:0] REG_CTRL  = 3'h2;
	localparam logic [2:0] REG_BASE  = 3'h3;
	localparam logic [2:0] REG_STAT  = 3'h5;
	localparam logic [2:0] REG_CAUSE = 3'h6;

	// field positions
	localparam int unsigned CTRL_CARD_EN_BIT = 0;
	localparam int unsigned CTRL_PAR_EN_BIT  = 1;
	localparam int unsigned STAT_CHANNEL_CHECK_N_BIT    = 7;
	localparam int unsigned STAT_AVAIL_BIT   = 6;
	localparam int unsigned CAUSE_DPAR_BIT   = 0;
	localparam int unsigned CAUSE_APAR_BIT   = 1;
	localparam int unsigned CAUSE_TMO_BIT    = 2;
	localparam int unsigned CMD_SPACE_BIT    = 7;

	// reset values
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] BASE_RST  = 8'h00;
	localparam logic [7:0] STAT_RST  = 8'hc0;
	localparam logic [7:0] STAT_MASK = 8'hc0;
	localparam logic [7:0] CAUSE_RST = 8'h00;

	// card identity, value is arbitrary
	localparam logic [15:0] CARD_ID = 16'h5a3c;

	// address bytes used by a 16-bit i/o address
	localparam logic [3:0] IO_ADDR_MASK = 4'h3;

	// read-side parity enable driver states
	typedef enum logic [1:0] {DP_IDLE, DP_DRIVE, DP_RESTORE} cpex_dp_t;

	// odd parity bit for one byte
	function automatic logic cpex_odd_par(input logic [7:0] b);
		return ~(^b);
	endfunction : cpex_odd_par

	// valid byte lanes from the transfer control signals
	function automatic logic [3:0] cpex_byte_valid(input logic be_mode,
		input logic a0, input logic high_byte_enable_n_n, input logic [3:0] be_n);
		if (be_mode) begin
			return ~be_n;
		end
		return {2'b00, ~high_byte_enable_n_n, ~a0};
	endfunction : cpex_byte_valid

endpackage : cpex_pkg

// [src/cpex_ifs.sv]
// interfaces between the parity checkers, the watchdog and the top
`timescale 1ns/1ps
interface cpex_par_if;
	logic [31:0] data;
	logic [3:0]  par;
	logic [3:0]  mask;
	logic        err;
	logic [3:0]  gen_par;
	modport chk (input data, input par, input mask,
		output err, output gen_par);
	modport src (output data, output par, output mask,
		input err, input gen_par);
endinterface : cpex_par_if

interface cpex_wd_if;
	logic req_active;
	logic expired;
	modport wd  (input req_active, output expired);
	modport mon (output req_active, input expired);
endinterface : cpex_wd_if

// [src/cpex_parity_chk.sv]
// byte-qualified parity checker and generator
`timescale 1ns/1ps
module cpex_parity_chk
	import cpex_pkg::*;
(
	cpex_par_if.chk p_if
);
	// only lanes in the mask can flag an error; parity is made on all lanes
	always_comb begin
		logic       e;
		logic [3:0] g;
		e = 1'b0;
		g = 4'h0;
		for (int i = 0; i < 4; i++) begin
			g[i] = cpex_odd_par(p_if.data[8*i +: 8]);
			e = e | (p_if.mask[i] & (p_if.par[i] != g[i]));
		end
		p_if.err     = e;
		p_if.gen_par = g;
	end
endmodule : cpex_parity_chk

// [src/cpex_request_n_a_wd.sv]
// preemption watchdog: flags an owner that holds on too long
`timescale 1ns/1ps
module cpex_request_n_a_wd
	import cpex_pkg::*;
(
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	cpex_wd_if.wd     wd_if
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic       exp_q;
	logic       exp_d;

	// saturating count of cycles with preemption pending
	always_comb begin
		cnt_d = cnt_q;
		exp_d = exp_q;
		if (!wd_if.req_active) begin
			cnt_d = 8'h00;
			exp_d = 1'b0;
		end else if (cnt_q == REQUEST_N_A_CNT_LAST) begin
			exp_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 8'h01;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 8'h00;
			exp_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end

	assign wd_if.expired = exp_q;
endmodule : cpex_request_n_a_wd

// [test/cpex_master_model.sv]
// controlling master model driving the channel side of the slave
`timescale 1ns/1ps
module cpex_master_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_channel_check_n,
	input  wire logic        i_selected_feedback_return_n,
	input  wire logic [31:0] i_data,
	input  wire logic [3:0]  i_data_par,
	input  wire logic        i_data_parity_enable_n,
	output logic             o_adl_n,
	output logic      [31:0] o_addr,
	output logic      [3:0]  o_addr_par,
	output logic             o_addr_parity_enable_n,
	output logic             o_mem_io,
	output logic             o_write,
	output logic             o_streaming,
	output logic             o_cmd_n,
	output logic             o_sd_strobe_n,
	output logic      [31:0] o_data,
	output logic      [3:0]  o_data_par,
	output logic             o_data_parity_enable_n,
	output logic             o_be_mode,
	output logic             o_high_byte_enable_n,
	output logic      [3:0]  o_byte_enables_n
);
	int chk_seen;
	logic burst_n, tc_n, fb_exc_en, fb_at_chk, rd_par_exc, fb_exc;

	// odd parity per byte lane
	function automatic logic [3:0] par4(input logic [31:0] v);
		for (int i = 0; i < 4; i++) par4[i] = ~(^v[8*i +: 8]);
	endfunction : par4

	// idle channel: every low-active control released high
	initial begin
		chk_seen = 0;
		{burst_n, tc_n, fb_exc_en} = 3'h7;
		{fb_at_chk, rd_par_exc, fb_exc} = 3'h0;
		{o_adl_n, o_cmd_n, o_sd_strobe_n} = 3'h7;
		{o_addr_parity_enable_n, o_data_parity_enable_n} = 2'h3;
		{o_mem_io, o_write, o_streaming, o_be_mode} = 4'h0;
		{o_addr, o_data, o_addr_par, o_data_par} = '0;
		{o_high_byte_enable_n, o_byte_enables_n} = 5'h1f;
	end

	// watched on reads and writes alike, parity or not
	always @(posedge i_ref_clk)
		if (i_channel_check_n === 1'b0) begin
			chk_seen <= chk_seen + 1;
			fb_at_chk <= i_selected_feedback_return_n;
		end

	// address phase; aflip corrupts lanes on purpose
	task automatic select(input logic [31:0] a, input logic [3:0] aflip,
		input logic wr, input logic strm, input logic bem,
		input logic [3:0] ben);
		@(posedge i_ref_clk);
		o_adl_n <= 1'b0;
		o_addr <= a;
		o_addr_par <= par4(a) ^ aflip;
		o_addr_parity_enable_n <= 1'b0;
		{o_mem_io, o_write, o_streaming} <= {1'b0, wr, strm};
		{o_be_mode, o_high_byte_enable_n} <= {bem, ben[1]};
		o_byte_enables_n <= ben;
		@(posedge i_ref_clk);
		o_adl_n <= 1'b1;
		o_addr_parity_enable_n <= 1'b1;
	endtask : select

	// one transfer; hold keeps parity enable up past the command
	task automatic xfer(input logic [31:0] a, input logic [3:0] aflip,
		input logic wr, input logic strm, input logic bem,
		input logic [3:0] ben, input logic [31:0] d,
		input logic [3:0] dflip, input int hold);
		select(a, aflip, wr, strm, bem, ben);
		o_cmd_n <= 1'b0;
		o_sd_strobe_n <= ~strm;
		o_data <= d;
		o_data_par <= par4(d) ^ dflip;
		o_data_parity_enable_n <= ~wr;
		burst_n <= ~strm;
		@(posedge i_ref_clk);
		// missing feedback while enabled: status, terminal count
		if (fb_exc_en && i_selected_feedback_return_n !== 1'b0) begin
			{fb_exc, tc_n} <= 2'b10;
		end
		{o_cmd_n, o_sd_strobe_n} <= 2'h3;
		repeat (hold) @(posedge i_ref_clk);
		o_data_parity_enable_n <= 1'b1;
		burst_n <= 1'b1;
		// released buses never show the stale value
		o_data <= ~d;
		o_addr <= ~a;
		@(posedge i_ref_clk);
		// read data checked against its parity while the slave enables it
		if (!wr && i_data_parity_enable_n === 1'b0
			&& i_data_par !== par4(i_data)) begin
			{rd_par_exc, tc_n} <= 2'b10;
		end
	endtask : xfer
endmodule : cpex_master_model

// [test/tb.sv]
// self-checking bench for the channel parity exception slave
`timescale 1ns/1ps
module tb
	import cpex_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst_n, wr_s, rd_s, grant, request_n_a, adl_n, mem_io;
	logic        write, strm, cmd_n, sds_n, m_dpen_n, be_mode;
	logic        high_byte_enable_n, addr_parity_enable_n, dpen_w, chk_w;
	logic        card_selected_feedback_n, channel_check_n, chk_oe;
	logic        dpo_n, dpo_oe, rd_oe, sel, go, wv, perr;
	logic [2:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, base;
	logic [31:0] user_rd, addr, m_data, data_w, wr_data, rd_data;
	logic [31:0] last_wd, last_rd;
	logic [3:0]  addr_par, m_par, par_w, byte_enables_n, rd_par, last_rp;
	int          n_fail = 0;
	int          total_checks = 0;
	int          cnt[7];
	logic [7:0]  rst_tab[8] = '{CARD_ID[7:0], CARD_ID[15:8], CTRL_RST,
		BASE_RST, 8'h00, STAT_RST, CAUSE_RST, 8'h00};

	always #20 ref_clk = ~ref_clk;

	// shared pins: slave drive wins while enabled, master otherwise; channel check pulled up
	assign dpen_w = dpo_oe ? dpo_n : m_dpen_n;
	assign chk_w = chk_oe ? channel_check_n : 1'b1;
	assign data_w = rd_oe ? rd_data : m_data;
	assign par_w = rd_oe ? rd_par : m_par;

	cpex_top dut (.i_ref_clk(ref_clk), .i_rst_n(rst_n),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(wr_s),
		.i_reg_rd(rd_s), .o_reg_rdata(reg_rdata), .i_adl_n(adl_n),
		.i_addr(addr), .i_addr_par(addr_par),
		.i_addr_parity_enable_n(addr_parity_enable_n), .i_mem_io(mem_io),
		.i_write(write), .i_streaming(strm), .i_cmd_n(cmd_n),
		.i_sd_strobe_n(sds_n), .i_data(data_w), .i_data_par(par_w),
		.i_data_parity_enable_n(dpen_w), .i_be_mode(be_mode),
		.i_high_byte_enable_n(high_byte_enable_n),
		.i_byte_enables_n(byte_enables_n), .i_arb_grant_state(grant),
		.i_request_n_a(request_n_a), .i_user_rd_data(user_rd),
		.o_card_selected_feedback_n(card_selected_feedback_n),
		.o_channel_check_n(channel_check_n), .o_channel_check_oe(chk_oe),
		.o_data_parity_enable_n(dpo_n), .o_data_parity_enable_oe(dpo_oe),
		.o_rd_data(rd_data), .o_rd_data_par(rd_par), .o_rd_data_oe(rd_oe),
		.o_selected(sel), .o_cmd_go(go), .o_wr_valid(wv),
		.o_wr_data(wr_data), .o_wr_par_err(perr));

	cpex_master_model m (.i_ref_clk(ref_clk), .i_channel_check_n(chk_w),
		.i_selected_feedback_return_n(card_selected_feedback_n),
		.i_data(data_w), .i_data_par(par_w), .i_data_parity_enable_n(dpen_w),
		.o_adl_n(adl_n), .o_addr(addr), .o_addr_par(addr_par),
		.o_addr_parity_enable_n(addr_parity_enable_n), .o_mem_io(mem_io),
		.o_write(write), .o_streaming(strm), .o_cmd_n(cmd_n),
		.o_sd_strobe_n(sds_n), .o_data(m_data), .o_data_par(m_par),
		.o_data_parity_enable_n(m_dpen_n), .o_be_mode(be_mode),
		.o_high_byte_enable_n(high_byte_enable_n),
		.o_byte_enables_n(byte_enables_n));

	// event counters: write, error, check, select, feedback, go, enable
	always @(posedge ref_clk) begin
		cnt[0] += (wv === 1'b1);
		cnt[1] += (perr === 1'b1);
		cnt[2] += (chk_oe === 1'b1 && channel_check_n === 1'b0);
		cnt[3] += (sel === 1'b1);
		cnt[4] += (card_selected_feedback_n === 1'b0);
		cnt[5] += (go === 1'b1);
		cnt[6] += (dpo_oe === 1'b1 && dpo_n === 1'b0);
		if (wv === 1'b1) last_wd = wr_data;
		if (rd_oe === 1'b1) {last_rd, last_rp} = {rd_data, rd_par};
	end

	// lanes that carry data for a given steering mode
	function automatic logic [3:0] lanes(input logic bem,
		input logic [3:0] ben);
		return bem ? ~ben : {2'b00, ~ben[1:0]};
	endfunction : lanes

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		{wr_s, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge ref_clk);
		wr_s <= 1'b0;
	endtask : reg_wr

	// read data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		{rd_s, reg_addr} <= {1'b1, a};
		@(posedge ref_clk);
		rd_s <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask : reg_rd

	// let pulses and the check pulse run out before counting
	task automatic settle;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : settle

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	initial begin
		repeat (60000) @(posedge ref_clk);
		n_fail++;
		results();
	end

	initial begin
		logic [31:0] a, d;
		logic [3:0]  ben;
		logic        bem;
		int          k;
		{rst_n, wr_s, rd_s, grant, reg_addr, reg_wdata} = '0;
		{request_n_a, user_rd} = {1'b1, 32'h0};
		void'($urandom(32'hf521));
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		// reset values, unmapped indices read zero
		for (int i = 0; i < 8; i++) reg_rd(3'(i), rst_tab[i]);
		base = 8'($urandom);
		reg_wr(REG_BASE, base);
		reg_wr(REG_CTRL, 8'h03);
		reg_wr(REG_ID_LO, 8'hff);
		reg_rd(REG_ID_LO, CARD_ID[7:0]);
		reg_rd(REG_BASE, base);
		// random writes, corruption only where nothing is carried
		for (int i = 0; i < 24; i++) begin
			a = {16'($urandom), base, 8'($urandom)};
			{bem, ben, d} = {1'($urandom), 4'($urandom), $urandom};
			if (!bem) a[0] = ben[0];
			cnt = '{default: 0};
			m.xfer(a, {2'($urandom), 2'b00}, 1'b1, 1'b0, bem, ben, d,
				4'($urandom) & ~lanes(bem, ben), 0);
			settle();
			check({cnt[0], last_wd}, {32'd1, d});
			check(cnt[1] + cnt[2], 0);
			check(cnt[3] > 0 && cnt[4] > 0, 1);
			check(cnt[5], a[7]);
		end
		// bad parity on a carried lane
		cnt = '{default: 0};
		m.xfer({16'h0, base, 8'h00}, 0, 1'b1, 1'b0, 1'b1, 0, $urandom, 4'h4, 0);
		settle();
		check(cnt[1], 1);
		check(cnt[2] >= 2, 1);
		reg_wr(REG_STAT, 8'h3f);
		reg_rd(REG_STAT, 8'h00);
		reg_rd(REG_CAUSE, 8'h01);
		reg_wr(REG_STAT, 8'h80);
		reg_rd(REG_STAT, STAT_RST);
		reg_rd(REG_CAUSE, 8'h00);
		// bad address parity on a command-space write
		cnt = '{default: 0};
		m.fb_exc_en = 1'b0;
		m.xfer({16'h0, base, 8'h80}, 4'h2, 1'b1, 1'b0, 1'b1, 0, 0, 0, 0);
		m.fb_exc_en = 1'b1;
		settle();
		check(cnt[3] + cnt[4], 0);
		check(cnt[5] + cnt[0], 0);
		check(cnt[2] >= 2 && m.chk_seen > 0, 1);
		check(m.fb_at_chk, 1);
		reg_rd(REG_STAT, STAT_RST);
		reg_rd(REG_CAUSE, 8'h02);
		reg_wr(REG_STAT, 8'h80);
		// read with parity enabled
		@(posedge ref_clk);
		user_rd <= $urandom;
		cnt = '{default: 0};
		m.xfer({16'h0, base, 8'h10}, 0, 1'b0, 1'b0, 1'b1, 0, 0, 0, 0);
		settle();
		check(last_rd, user_rd);
		check(last_rp, m.par4(user_rd));
		check(cnt[6] > 0, 1);
		check({m.rd_par_exc, m.fb_exc, m.tc_n}, 3'b001);
		// streaming write: check lasts as long as the held enable
		cnt = '{default: 0};
		m.xfer({16'h0, base, 8'h20}, 0, 1'b1, 1'b1, 1'b1, 0, 0, 4'h1, 6);
		settle();
		check(cnt[0], 1);
		check(cnt[2] >= 6, 1);
		check(chk_oe, 1'b0);
		check(m.burst_n, 1'b1);
		reg_wr(REG_STAT, 8'h80);
		// parity disabled: nothing checked, no enable driven
		reg_wr(REG_CTRL, 8'h01);
		cnt = '{default: 0};
		m.xfer({16'h0, base, 8'h00}, 4'h3, 1'b1, 1'b0, 1'b1, 0, 0, 4'hf, 0);
		m.xfer({16'h0, base, 8'h00}, 0, 1'b0, 1'b0, 1'b1, 0, 0, 0, 0);
		settle();
		check(cnt[3] > 0, 1);
		check(cnt[1] + cnt[2] + cnt[6], 0);
		// owner held past preemption is forced off
		reg_wr(REG_CTRL, 8'h03);
		m.select({16'h0, base, 8'h00}, 0, 1'b0, 1'b0, 1'b1, 0);
		@(posedge ref_clk);
		{request_n_a, grant} <= 2'b01;
		k = 0;
		while (sel !== 1'b0 && k < 300) begin
			@(posedge ref_clk);
			k++;
		end
		check(k >= 195 && k <= 199, 1);
		if (k == 300)
			results();
		{request_n_a, grant} <= 2'b10;
		reg_rd(REG_CAUSE, 8'h04);
		results();
	end
endmodule : tb
